// *** wt_defines.vh ***
`ifndef WT_DEFINES_VH
`define WT_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define WT_IDX_CTRL        16'h4026
`define WT_IDX_RELOAD      16'h4027
`define WT_IDX_CFG         16'h4028
`define WT_IDX_RSTSTAT     16'h4029
`define WT_IDX_COUNT       16'h402a
`define WT_IDX_IRQ_STAT    16'h402b
`define WT_IDX_IRQ_EN      16'h402c
`define WT_IDX_IRQ_CLR     16'h402d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WT_CTRL_REFRESH_BIT   0
`define WT_CFG_ENABLE_BIT     0
`define WT_RSTSTAT_WDOG_BIT   0
`define WT_EVT_OVERFLOW_BIT   0
`define WT_EVT_REFRESH_BIT    1
`define WT_EVT_COUNT          2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define WT_RELOAD_RST      8'h00
`define WT_CFG_RST         1'b0
`define WT_COUNT_START     16'h0000
`define WT_COUNT_FULL      16'hffff
`define WT_PULSE_TICKS     3'h4
`define WT_RESTART_ADDR    16'h0000

`endif

// *** wt_sync.v ***
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Two-flop synchroniser with rising-edge tick
// ----------------------------------------------------------------
module wt_sync
(
   input  wire clk,
   input  wire srst,
   input  wire ce,
   input  wire async_in,
   output reg  tick_q
);

   reg stage1_q;
   reg stage2_q;
   reg stage3_q;

   // Stage one feeds only stage two, so a metastable value never fans out
   always @(posedge clk)
   begin
      if (srst)
      begin
         stage1_q <= 1'b0;
         stage2_q <= 1'b0;
         stage3_q <= 1'b0;
         tick_q   <= 1'b0;
      end
      else if (ce)
      begin
         stage1_q <= async_in;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         tick_q   <= stage2_q & ~stage3_q;
      end
   end

endmodule // wt_sync

// *** wt_irq.v ***
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Sticky event status, enable and level interrupt
// ----------------------------------------------------------------
module wt_irq
#(
   parameter N = 2
)
(
   input  wire         clk,
   input  wire         srst,
   input  wire         ce,
   input  wire [N-1:0] events,
   input  wire         wr_enable,
   input  wire         wr_clear,
   input  wire [N-1:0] wr_data,
   output reg  [N-1:0] status_q,
   output reg  [N-1:0] enable_q,
   output reg          irq_q
);

   genvar i;

   generate
      for (i = 0; i < N; i = i + 1)
      begin : g_bit
         // A new event beats a clear in the same cycle
         always @(posedge clk)
         begin
            if (srst)
               status_q[i] <= 1'b0;
            else if (ce)
               status_q[i] <= events[i] | (status_q[i] & ~(wr_clear & wr_data[i]));
         end
      end
   endgenerate

   always @(posedge clk)
   begin
      if (srst)
      begin
         enable_q <= {N{1'b0}};
         irq_q    <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_enable)
            enable_q <= wr_data;
         irq_q <= |(status_q & enable_q);
      end
   end

endmodule // wt_irq

// *** wt_watchdog.v ***
// Our own choice: the APB register port.
`timescale 1ns/100ps
`include "wt_defines.vh"

module wt_watchdog
(
   input  wire        CLK,
   input  wire        SRST,
   input  wire        CE,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [17:0] PADDR,
   input  wire [31:0] PWDATA,
   input  wire [3:0]  PSTRB,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   input  wire        SLOW_OSC_CLOCK,
   input  wire        STANDBY,
   input  wire        SLEEP,
   input  wire        EMULATION,
   output reg         SYS_RESET,
   output reg  [15:0] RESTART_ADDR,
   output wire        IRQ
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [2:0] ST_OFF  = 3'b001;
   localparam [2:0] ST_RUN  = 3'b010;
   localparam [2:0] ST_FIRE = 3'b100;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [15:0] count_q;
   reg  [15:0] count_d;
   reg  [2:0]  pulse_cnt_q;
   reg  [2:0]  pulse_cnt_d;
   reg         sys_reset_d;
   reg  [7:0]  reload_high_byte_q;
   reg         watchdog_enable_cfg_q;
   reg         reset_cause_watchdog_flag_q;
   reg  [31:0] rd_data;
   reg         rd_hit;
   reg         ev_overflow;
   reg         ev_refresh;

   wire        slow_tick;
   wire        access;
   wire        wr_commit;
   wire        wr_lane0;
   wire        watchdog_refresh;
   wire        run_ok;
   wire        frozen;
   wire        wr_reload;
   wire        wr_cfg;
   wire        wr_rststat;
   wire        wr_irq_en;
   wire        wr_irq_clr;
   wire        at_full;
   wire        pulse_last;
   wire [`WT_EVT_COUNT-1:0] irq_status;
   wire [`WT_EVT_COUNT-1:0] irq_enable;
   wire [`WT_EVT_COUNT-1:0] irq_events;

   // ----------------------------------------------------------------
   // Address decode helper
   // ----------------------------------------------------------------
   function wt_hit;
      input [17:0] addr;
      input [15:0] idx;
      begin
         wt_hit = (addr[17:2] == idx);
      end
   endfunction

   // ----------------------------------------------------------------
   // Slow oscillator crossing
   // ----------------------------------------------------------------
   // The slow clock is sampled, not used as a clock, so the whole block stays in one domain
   wt_sync u_slow_sync
   (
      .clk      (CLK),
      .srst     (SRST),
      .ce       (CE),
      .async_in (SLOW_OSC_CLOCK),
      .tick_q   (slow_tick)
   );

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign access    = PSEL & PENABLE;
   assign wr_commit = access & PREADY & PWRITE & rd_hit;
   assign wr_lane0  = wr_commit & PSTRB[0];

   // Unmapped words answer with an error and zero data
   always @*
   begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (PADDR[17:2])
         `WT_IDX_CTRL:
            rd_data = 32'h0000_0000;
         `WT_IDX_RELOAD:
            rd_data = {24'h00_0000, reload_high_byte_q};
         `WT_IDX_CFG:
            rd_data = {31'h0000_0000, watchdog_enable_cfg_q};
         `WT_IDX_RSTSTAT:
            rd_data = {31'h0000_0000, reset_cause_watchdog_flag_q};
         `WT_IDX_COUNT:
            rd_data = {16'h0000, count_q};
         `WT_IDX_IRQ_STAT:
            rd_data = {30'h0000_0000, irq_status};
         `WT_IDX_IRQ_EN:
            rd_data = {30'h0000_0000, irq_enable};
         `WT_IDX_IRQ_CLR:
            rd_data = 32'h0000_0000;
         default:
            rd_hit = 1'b0;
      endcase
   end

   // One wait state: data is prepared in the first access cycle, so PREADY can come from a flop
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end
      else if (CE)
      begin
         if (access & ~PREADY)
         begin
            PREADY  <= 1'b1;
            PSLVERR <= ~rd_hit;
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_data;
         end
         else
         begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   assign watchdog_refresh = wr_lane0 & wt_hit(PADDR, `WT_IDX_CTRL)
                             & PWDATA[`WT_CTRL_REFRESH_BIT];

   // ----------------------------------------------------------------
   // Write strobes
   // ----------------------------------------------------------------
   // Lane zero carries every field, so a write with that strobe low is dropped
   assign wr_reload  = wr_lane0 & wt_hit(PADDR, `WT_IDX_RELOAD);
   assign wr_cfg     = wr_lane0 & wt_hit(PADDR, `WT_IDX_CFG);
   assign wr_rststat = wr_lane0 & wt_hit(PADDR, `WT_IDX_RSTSTAT);
   assign wr_irq_en  = wr_lane0 & wt_hit(PADDR, `WT_IDX_IRQ_EN);
   assign wr_irq_clr = wr_lane0 & wt_hit(PADDR, `WT_IDX_IRQ_CLR);

   // Reload byte is plain storage; it is only read at refresh time, so write order does not matter
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         reload_high_byte_q    <= `WT_RELOAD_RST;
         watchdog_enable_cfg_q <= `WT_CFG_RST;
      end
      else if (CE)
      begin
         if (wr_reload)
            reload_high_byte_q <= PWDATA[7:0];
         if (wr_cfg)
            watchdog_enable_cfg_q <= PWDATA[`WT_CFG_ENABLE_BIT];
      end
   end

   // Cause flag: set by an overflow, cleared by writing one; the set wins
   always @(posedge CLK)
   begin
      if (SRST)
         reset_cause_watchdog_flag_q <= 1'b0;
      else if (CE)
      begin
         if (ev_overflow)
            reset_cause_watchdog_flag_q <= 1'b1;
         else if (wr_rststat & PWDATA[`WT_RSTSTAT_WDOG_BIT])
            reset_cause_watchdog_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Watchdog counter
   // ----------------------------------------------------------------
   assign run_ok = watchdog_enable_cfg_q & ~EMULATION;
   assign frozen = STANDBY | SLEEP;
   // Full-scale compare is a level, so a counter parked at full scale by a freeze still fires
   assign at_full    = (count_q == `WT_COUNT_FULL);
   assign pulse_last = (pulse_cnt_q == `WT_PULSE_TICKS - 3'h1);

   always @*
   begin
      state_d     = state_q;
      count_d     = count_q;
      pulse_cnt_d = pulse_cnt_q;
      sys_reset_d = SYS_RESET;
      ev_overflow = 1'b0;
      ev_refresh  = 1'b0;
      case (state_q)
         ST_OFF:
         begin
            // Held at zero while disabled, so enabling always starts a fresh interval
            count_d = `WT_COUNT_START;
            if (run_ok)
               state_d = ST_RUN;
         end
         ST_RUN:
         begin
            if (~run_ok)
            begin
               state_d = ST_OFF;
               count_d = `WT_COUNT_START;
            end
            else if (watchdog_refresh)
            begin
               // Refresh outranks overflow, so a late refresh still rescues the system
               count_d    = {reload_high_byte_q, 8'h00};
               ev_refresh = 1'b1;
            end
            else if (at_full)
            begin
               state_d     = ST_FIRE;
               pulse_cnt_d = 3'h0;
               sys_reset_d = 1'b1;
               ev_overflow = 1'b1;
            end
            else if (slow_tick & ~frozen)
               count_d = count_q + 16'h0001;
         end
         ST_FIRE:
         begin
            // Once started the pulse always completes, even if emulation begins meanwhile
            if (slow_tick)
            begin
               if (pulse_last)
               begin
                  state_d     = ST_OFF;
                  sys_reset_d = 1'b0;
                  count_d     = `WT_COUNT_START;
               end
               else
                  pulse_cnt_d = pulse_cnt_q + 3'h1;
            end
         end
         default:
         begin
            state_d     = ST_OFF;
            count_d     = `WT_COUNT_START;
            sys_reset_d = 1'b0;
         end
      endcase
   end

   always @(posedge CLK)
   begin
      if (SRST)
      begin
         state_q     <= ST_OFF;
         count_q     <= `WT_COUNT_START;
         pulse_cnt_q <= 3'h0;
      end
      else if (CE)
      begin
         state_q     <= state_d;
         count_q     <= count_d;
         pulse_cnt_q <= pulse_cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Reset outputs
   // ----------------------------------------------------------------
   // The pulse is a plain flop so the system reset tree never sees decode glitches
   always @(posedge CLK)
   begin
      if (SRST)
         SYS_RESET <= 1'b0;
      else if (CE)
         SYS_RESET <= sys_reset_d;
   end

   // Restart vector is fixed; it is reloaded on every overflow so the target cannot drift
   always @(posedge CLK)
   begin
      if (SRST)
         RESTART_ADDR <= `WT_RESTART_ADDR;
      else if (CE & ev_overflow)
         RESTART_ADDR <= `WT_RESTART_ADDR;
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign irq_events[`WT_EVT_OVERFLOW_BIT] = ev_overflow;
   assign irq_events[`WT_EVT_REFRESH_BIT]  = ev_refresh;

   wt_irq #(.N(`WT_EVT_COUNT)) u_irq
   (
      .clk       (CLK),
      .srst      (SRST),
      .ce        (CE),
      .events    (irq_events),
      .wr_enable (wr_irq_en),
      .wr_clear  (wr_irq_clr),
      .wr_data   (PWDATA[`WT_EVT_COUNT-1:0]),
      .status_q  (irq_status),
      .enable_q  (irq_enable),
      .irq_q     (IRQ)
   );

endmodule // wt_watchdog

// *** wt_watchdog_props.sv ***
`timescale 1ns/100ps

// ------------------------------------------
// Port checks of the watchdog block
// ------------------------------------------
module wt_watchdog_props
(
   input wire        CLK,
   input wire        SRST,
   input wire        CE,
   input wire        PSEL,
   input wire        PENABLE,
   input wire [17:0] PADDR,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   input wire        SLOW_OSC_CLOCK,
   input wire        STANDBY,
   input wire        SLEEP,
   input wire        EMULATION,
   input wire        SYS_RESET,
   input wire [15:0] RESTART_ADDR,
   input wire        IRQ
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   // Slow pin rises seen while the pulse is high; assumes the slow period exceeds the synchroniser delay
   reg       slow_prev_q;
   reg [2:0] slow_rises_q;

   always @(posedge CLK)
   begin
      if (CE)
         slow_prev_q <= SLOW_OSC_CLOCK;
      if (SRST || !SYS_RESET)
         slow_rises_q <= 3'h0;
      else if (CE && SLOW_OSC_CLOCK && !slow_prev_q && slow_rises_q != 3'h7)
         slow_rises_q <= slow_rises_q + 3'h1;
   end

   a_ready_single: assert property (PREADY |=> !PREADY)
      else $error("ready held over one cycle");
   a_ready_answer: assert property (CE && PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("access phase not answered");
   a_err_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("error without ready or with data");
   a_idle_data: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside answer");
   a_mapped_ok: assert property (PREADY && PADDR[17:2] >= 16'h4026 && PADDR[17:2] <= 16'h402d |-> !PSLVERR)
      else $error("error on mapped register");
   a_restart_zero: assert property (RESTART_ADDR == 16'h0000)
      else $error("restart address not zero");
   a_pulse_min: assert property ($rose(SYS_RESET) |-> SYS_RESET [*6])
      else $error("reset pulse too short");
   a_pulse_ends: assert property ($rose(SYS_RESET) |-> ##[8:1000] !SYS_RESET)
      else $error("reset pulse never ends");
   a_pulse_width: assert property ($fell(SYS_RESET) |-> slow_rises_q == 3'h4)
      else $error("reset pulse not four slow cycles");
   a_emul_quiet: assert property ($rose(SYS_RESET) |-> !$past(EMULATION, 2))
      else $error("reset raised in emulation");
   a_freeze_quiet: assert property ((STANDBY || SLEEP) [*3] |-> !$rose(SYS_RESET))
      else $error("reset raised while frozen");
   a_reset_quiet: assert property ($fell(SRST) |-> !PREADY && !SYS_RESET && !IRQ)
      else $error("outputs active after reset");

   cover property ($rose(SYS_RESET));
   cover property (PSLVERR);
   cover property ($rose(IRQ));
endmodule // wt_watchdog_props

bind wt_watchdog wt_watchdog_props wt_watchdog_props_i (.CLK(CLK), .SRST(SRST), .CE(CE), .PSEL(PSEL),
   .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .SLOW_OSC_CLOCK(SLOW_OSC_CLOCK),
   .STANDBY(STANDBY), .SLEEP(SLEEP), .EMULATION(EMULATION), .SYS_RESET(SYS_RESET),
   .RESTART_ADDR(RESTART_ADDR), .IRQ(IRQ));

// *** wt_watchdog_bench.sv ***
`timescale 1ns/100ps
`include "wt_defines.vh"

module wt_watchdog_bench;
   reg         CLK = 1'b0;
   reg         SRST = 1'b1;
   reg         CE = 1'b1;
   reg         PSEL = 1'b0;
   reg         PENABLE = 1'b0;
   reg         PWRITE = 1'b0;
   reg  [17:0] PADDR = 18'h0;
   reg  [31:0] PWDATA = 32'h0;
   reg  [3:0]  PSTRB = 4'hf;
   reg         SLOW_OSC_CLOCK = 1'b0;
   reg         STANDBY = 1'b0;
   reg         SLEEP = 1'b0;
   reg         EMULATION = 1'b0;
   wire [31:0] PRDATA;
   wire        PREADY;
   wire        PSLVERR;
   wire        SYS_RESET;
   wire [15:0] RESTART_ADDR;
   wire        IRQ;
   integer     bad_count = 0;
   integer     checks_done = 0;
   integer     seed = 32'hb0f6;
   integer     mcount;
   integer     i;
   reg  [31:0] rd;
   reg         err;
   reg  [7:0]  rel;

   always #25 CLK = ~CLK;

   wt_watchdog wt_watchdog_i (.CLK(CLK), .SRST(SRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .SLOW_OSC_CLOCK(SLOW_OSC_CLOCK), .STANDBY(STANDBY),
      .SLEEP(SLEEP), .EMULATION(EMULATION), .SYS_RESET(SYS_RESET), .RESTART_ADDR(RESTART_ADDR),
      .IRQ(IRQ));

   // ------------------------------------------
   // Shared tasks
   // ------------------------------------------
   task results;
      begin
         $display("checks %0d mismatches %0d", checks_done, bad_count);
         if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            bad_count = bad_count + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   // Values are sampled at the edge that sees PREADY high, before it falls
   task apb(input wr, input [15:0] idx, input [31:0] wd);
      integer n;
      begin
         n = 0;
         @(posedge CLK);
         PSEL <= 1'b1;
         PWRITE <= wr;
         PADDR <= {idx, 2'b00};
         PWDATA <= wd;
         @(posedge CLK);
         PENABLE <= 1'b1;
         @(posedge CLK);
         while (PREADY !== 1'b1 && n < 20)
         begin
            n = n + 1;
            @(posedge CLK);
         end
         rd = PRDATA;
         err = PSLVERR;
         PSEL <= 1'b0;
         PENABLE <= 1'b0;
         if (PREADY !== 1'b1)
         begin
            chk("bus timeout", 1, 0);
            results;
         end
      end
   endtask

   // One slow period is eight system clocks, so the synchroniser settles within it
   task ticks(input integer n);
      repeat (n)
      begin
         @(posedge CLK);
         SLOW_OSC_CLOCK <= 1'b1;
         repeat (4) @(posedge CLK);
         SLOW_OSC_CLOCK <= 1'b0;
         repeat (3) @(posedge CLK);
      end
   endtask

   // ------------------------------------------
   // Main sequence
   // ------------------------------------------
   initial
   begin
      repeat (10) @(posedge CLK);
      SRST <= 1'b0;
      for (i = 0; i < 7; i = i + 1)
      begin
         apb(0, `WT_IDX_CTRL + i, 0);
         chk("reset value", 0, rd);
      end
      apb(0, 16'h402e, 0);
      chk("unmapped error", 1, {31'h0, err});
      PSTRB <= 4'he;
      apb(1, `WT_IDX_RELOAD, 32'h5a);
      PSTRB <= 4'hf;
      apb(0, `WT_IDX_RELOAD, 0);
      chk("strobe-less write", 0, rd);
      $display("reset test done");
      rd = $random(seed);
      rel = rd[7:0];
      apb(1, `WT_IDX_RELOAD, {24'h0, rel});
      apb(1, `WT_IDX_IRQ_EN, 32'h3);
      apb(1, `WT_IDX_CFG, 32'h1);
      ticks(5);
      mcount = 5;
      apb(0, `WT_IDX_COUNT, 0);
      chk("count after enable", mcount, rd);
      apb(1, `WT_IDX_COUNT, 32'h1234);
      apb(1, `WT_IDX_CTRL, 32'h0);
      apb(0, `WT_IDX_COUNT, 0);
      chk("count after zero write", mcount, rd);
      apb(1, `WT_IDX_CTRL, 32'h1);
      ticks(3);
      mcount = rel * 256 + 3;
      apb(0, `WT_IDX_COUNT, 0);
      chk("count after refresh", mcount, rd);
      apb(0, `WT_IDX_IRQ_STAT, 0);
      chk("refresh event", 2, rd);
      chk("irq raised", 1, IRQ);
      apb(1, `WT_IDX_IRQ_CLR, 32'h2);
      repeat (2) @(posedge CLK);
      chk("irq cleared", 0, IRQ);
      $display("refresh test done");
      for (i = 0; i < 3; i = i + 1)
      begin
         STANDBY <= (i == 0);
         SLEEP <= (i == 1);
         CE <= (i != 2);
         ticks(4);
         STANDBY <= 1'b0;
         SLEEP <= 1'b0;
         CE <= 1'b1;
         apb(0, `WT_IDX_COUNT, 0);
         chk("frozen count", mcount, rd);
      end
      EMULATION <= 1'b1;
      ticks(3);
      apb(0, `WT_IDX_COUNT, 0);
      chk("emulation count", 0, rd);
      chk("emulation reset", 0, SYS_RESET);
      EMULATION <= 1'b0;
      $display("freeze test done");
      apb(1, `WT_IDX_RELOAD, 32'hff);
      apb(1, `WT_IDX_CTRL, 32'h1);
      ticks(254);
      chk("early reset", 0, SYS_RESET);
      ticks(1);
      chk("overflow reset", 1, SYS_RESET);
      ticks(3);
      chk("pulse held", 1, SYS_RESET);
      ticks(1);
      chk("pulse ended", 0, SYS_RESET);
      chk("restart address", 0, RESTART_ADDR);
      apb(0, `WT_IDX_RSTSTAT, 0);
      chk("reset cause", 1, rd);
      apb(0, `WT_IDX_IRQ_STAT, 0);
      chk("overflow event", 3, rd);
      apb(1, `WT_IDX_RSTSTAT, 32'h1);
      apb(0, `WT_IDX_RSTSTAT, 0);
      chk("cause cleared", 0, rd);
      apb(0, `WT_IDX_COUNT, 0);
      chk("count restarts", 0, rd);
      $display("overflow test done");
      results;
   end
endmodule // wt_watchdog_bench
